// File: rtl/sgu_pkg.sv
package sgu_pkg;

  // ****************************************
  // Guard storage layout
  // ****************************************
  localparam int GUARD_AW = 4;
  localparam int GUARD_DEPTH = 16;
  localparam logic [3:0] LOC_GROUP0 = 4'h0;
  localparam logic [3:0] LOC_GROUP1 = 4'h1;
  localparam logic [3:0] LOC_GROUP7 = 4'h7;
  localparam logic [3:0] LOC_ERASE_INHIBIT = 4'h8;
  localparam logic [3:0] LOC_SPARE = 4'h9;
  localparam logic [3:0] LOC_LAST = 4'hf;
  localparam logic [7:0] GUARD_ERASED = 8'hff;
  localparam logic [7:0] INHIBIT_ON = 8'h00;

  // ****************************************
  // Sector and block geometry
  // ****************************************
  localparam int SECTOR_LSB = 12;
  localparam int SECTOR_MSB = 17;
  localparam int GROUP_LSB = 15;
  localparam int NUM_BLOCKS = 4;

  // ****************************************
  // Opcodes and frame sizes
  // ****************************************
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_UNLOCK = 8'h26;
  localparam logic [7:0] OP_LOCK = 8'h24;
  localparam logic [7:0] DEF_OP_GUARD_READ = 8'h48;
  localparam logic [7:0] DEF_OP_GUARD_ERASE = 8'h44;
  localparam logic [7:0] DEF_OP_GUARD_PROG = 8'h42;
  localparam logic [3:0][7:0] DEF_GUARD_KEYS = {8'h06, 8'h5a, 8'ha5, 8'h06};
  localparam logic [2:0] SEQ_LEN = 3'd4;
  localparam logic [2:0] LOCK_BYTES = 3'd1;
  localparam logic [2:0] UNLOCK_BYTES = 3'd4;
  localparam logic [2:0] IDX_OPCODE = 3'd1;
  localparam logic [2:0] IDX_ADDR_FIRST = 3'd2;
  localparam logic [2:0] IDX_ADDR_LAST = 3'd4;
  localparam logic [2:0] IDX_DATA = 3'd5;
  localparam logic [2:0] BYTES_SAT = 3'd7;
  localparam logic [2:0] BIT_LAST = 3'd7;
  localparam logic [8:0] PROG_MAX = 9'h100;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int ERASE_TIME_MS = 10;
  localparam int PROG_TIME_MS = 5;
  localparam int ERASE_CYCLES_DEF = ERASE_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int PROG_CYCLES_DEF = PROG_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int BUSY_W = 20;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_PROG = 4'b0010,
    ST_ERASE = 4'b0100,
    ST_BUSY = 4'b1000
  } sgu_state_t;

  typedef struct packed {
    logic [7:0] data;
    logic [2:0] idx;
  } sgu_rx_t;

  typedef struct packed {
    logic valid;
    logic [5:0] sector;
  } sgu_unlock_t;

  // Whole frame of n bytes with no stray bits
  function automatic logic frame_exact(input logic [2:0] bytes, input logic [2:0] bits, input logic [2:0] n);
    frame_exact = (bytes == n) && (bits == 3'd0);
  endfunction

  // Upper bp blocks are covered by block protection
  function automatic logic block_locked(input logic [2:0] bp, input logic [1:0] blk);
    block_locked = (NUM_BLOCKS - int'(blk)) <= int'(bp);
  endfunction

endpackage

// File: rtl/sgu_guard_mem.sv
`timescale 1ns/10ps
module sgu_guard_mem
  import sgu_pkg::*;
(
  input logic clk,
  input logic nrst,
  input logic we,
  input logic [GUARD_AW-1:0] waddr,
  input logic [7:0] wdata,
  input logic [GUARD_AW-1:0] raddr_a,
  output logic [7:0] rdata_a,
  input logic [GUARD_AW-1:0] raddr_b,
  output logic [7:0] rdata_b,
  output logic [7:0] inhibit
);

  // ****************************************
  // Storage, reset stands in for the erased state
  // ****************************************
  logic [7:0] mem [GUARD_DEPTH];

  for (genvar i = 0; i < GUARD_DEPTH; i++) begin : g_word
    always_ff @(posedge clk) begin
      if (!nrst) begin
        mem[i] <= GUARD_ERASED;
      end else if (we && (waddr == GUARD_AW'(i))) begin
        mem[i] <= wdata;
      end
    end
  end

  // Registered read ports
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdata_a <= GUARD_ERASED;
      rdata_b <= GUARD_ERASED;
      inhibit <= GUARD_ERASED;
    end else begin
      rdata_a <= mem[raddr_a];
      rdata_b <= mem[raddr_b];
      inhibit <= mem[LOC_ERASE_INHIBIT];
    end
  end

endmodule // sgu_guard_mem

// File: rtl/sgu_top.sv
// Functional notes
// - One guard bit per sector, zero protects
// - Guard protection outranks block-protect bits
// - Sector n at byte n/8, bit n%8
// - Guard read shifts bytes out MSB first
// - Location advances after every output byte
// - Chip select high ends a read
// - Erase needs five correct instructions
// - Program needs five instructions, 1-256 bytes
// - Erase and program stay busy like array
// - Opcode 26h unlocks; four-byte command
// - Opcode 24h relocks the unlocked sector
// - Unlock matters only inside block-protected areas
// - Only one sector unlocked at once
// - Unlock ignores twelve low location bits
// - Unlock needs exactly 32 clocks
// - Other sectors of block stay read-only
`timescale 1ns/10ps
module sgu_top
  import sgu_pkg::*;
#(
  parameter logic [7:0] OP_GUARD_READ = DEF_OP_GUARD_READ,
  parameter logic [7:0] OP_GUARD_ERASE = DEF_OP_GUARD_ERASE,
  parameter logic [7:0] OP_GUARD_PROG = DEF_OP_GUARD_PROG,
  parameter logic [3:0][7:0] GUARD_KEYS = DEF_GUARD_KEYS,
  parameter int ERASE_CYCLES = ERASE_CYCLES_DEF,
  parameter int PROG_CYCLES = PROG_CYCLES_DEF
)
(
  input logic clk,
  input logic nrst,
  input logic spi_sck,
  input logic spi_cs_n,
  input logic serial_in_line,
  output logic serial_out,
  output logic serial_out_oe,
  input logic block_protect_bit0,
  input logic block_protect_bit1,
  input logic block_protect_bit2,
  input logic [23:0] query_addr,
  output logic query_writable,
  output logic whole_erase_blocked,
  output logic guard_busy,
  output logic unlock_active,
  output logic write_enable_latch
);

  // ****************************************
  // Link side, clocked by the serial clock
  // ****************************************
  logic fresh;
  logic [2:0] lk_bits;
  logic [2:0] lk_bytes;
  logic [7:0] lk_shift;
  sgu_rx_t lk_rx;
  logic lk_tgl;
  logic lk_ftgl;
  logic rd_cmd;
  logic [7:0] tx_sh;
  logic tx_oe;
  logic done;
  logic [7:0] in_byte;
  logic [7:0] rdata_a;

  assign done = (lk_bits == BIT_LAST) && !fresh;
  assign in_byte = {lk_shift[6:0], serial_in_line};

  // First edge of a frame marker, raised while deselected
  always_ff @(posedge spi_sck or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      fresh <= 1'b1;
    end else begin
      fresh <= 1'b0;
    end
  end

  // Bit and byte counting; counts hold after the frame for the clk side
  always_ff @(posedge spi_sck or negedge nrst) begin
    if (!nrst) begin
      lk_bits <= 3'd0;
      lk_bytes <= 3'd0;
      lk_shift <= 8'h00;
      lk_rx <= '0;
      lk_tgl <= 1'b0;
      lk_ftgl <= 1'b0;
    end else begin
      lk_shift <= in_byte;
      lk_bits <= fresh ? 3'd1 : lk_bits + 3'd1;
      if (fresh) begin
        lk_bytes <= 3'd0;
        lk_ftgl <= ~lk_ftgl;
      end else if (done && (lk_bytes != BYTES_SAT)) begin
        lk_bytes <= lk_bytes + 3'd1;
      end
      if (done) begin
        lk_rx.data <= in_byte;
        lk_rx.idx <= (lk_bytes == BYTES_SAT) ? BYTES_SAT : lk_bytes + 3'd1;
        lk_tgl <= ~lk_tgl;
      end
    end
  end

  // Read opcode seen in this frame
  always_ff @(posedge spi_sck or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      rd_cmd <= 1'b0;
    end else if (done && (lk_bytes == 3'd0)) begin
      rd_cmd <= (in_byte == OP_GUARD_READ);
    end
  end

  // Output shifter on the falling edge; data word is stable for a full byte
  always_ff @(negedge spi_sck or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      tx_sh <= 8'h00;
      tx_oe <= 1'b0;
    end else if (rd_cmd && (lk_bits == 3'd0) && (lk_bytes >= IDX_ADDR_LAST)) begin
      tx_sh <= rdata_a;
      tx_oe <= 1'b1;
    end else begin
      tx_sh <= {tx_sh[6:0], 1'b0};
    end
  end

  assign serial_out = tx_sh[7];
  assign serial_out_oe = tx_oe;

  // ****************************************
  // Crossing into the system clock
  // ****************************************
  logic [2:0] cs_sy;
  logic [2:0] tg_sy;
  logic [1:0] fr_sy;
  logic byte_ev;
  logic frame_end;

  // Two flops per crossing, third only for edge detection
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cs_sy <= 3'b111;
      tg_sy <= 3'b000;
      fr_sy <= 2'b00;
    end else begin
      cs_sy <= {cs_sy[1:0], spi_cs_n};
      tg_sy <= {tg_sy[1:0], lk_tgl};
      fr_sy <= {fr_sy[0], lk_ftgl};
    end
  end

  assign byte_ev = tg_sy[1] ^ tg_sy[2];
  assign frame_end = cs_sy[1] & ~cs_sy[2];

  // ****************************************
  // Command engine
  // ****************************************
  sgu_state_t st;
  logic [7:0] opcode;
  logic [23:0] addr;
  logic [23:0] next_addr;
  logic [3:0] rd_ptr;
  logic [3:0] wr_ptr;
  logic [8:0] prog_cnt;
  logic [BUSY_W-1:0] busy_cnt;
  logic [3:0] erase_idx;
  logic [2:0] step;
  logic wel;
  sgu_unlock_t unl;
  logic fr_seen;
  logic clocked;
  logic ex1;
  logic ex4;
  logic idle;
  logic take_wren;
  logic take_unlock;
  logic take_lock;
  logic take_erase;
  logic take_prog;
  logic prog_we;
  logic key_ok;

  assign next_addr = {addr[15:0], lk_rx.data};
  assign clocked = fr_sy[1] != fr_seen;
  assign ex1 = clocked && frame_exact(lk_bytes, lk_bits, LOCK_BYTES);
  assign ex4 = clocked && frame_exact(lk_bytes, lk_bits, UNLOCK_BYTES);
  assign idle = (st == ST_IDLE);
  assign key_ok = (step < SEQ_LEN) && (opcode == GUARD_KEYS[2'(step)]);
  assign take_wren = frame_end && idle && ex1 && (opcode == OP_WREN);
  // Same-sector unlock is harmless; a different one needs a lock first
  assign take_unlock = frame_end && idle && ex4 && (opcode == OP_UNLOCK) && wel &&
    (!unl.valid || (unl.sector == addr[SECTOR_MSB:SECTOR_LSB]));
  assign take_lock = frame_end && idle && ex1 && (opcode == OP_LOCK);
  assign take_erase = frame_end && idle && ex1 && (opcode == OP_GUARD_ERASE) && (step == SEQ_LEN);
  assign take_prog = byte_ev && idle && (lk_rx.idx == IDX_OPCODE) && (lk_rx.data == OP_GUARD_PROG) &&
    (step == SEQ_LEN);
  assign prog_we = (st == ST_PROG) && byte_ev && (lk_rx.idx >= IDX_DATA) && (prog_cnt < PROG_MAX);

  // Opcode and location capture from received bytes
  always_ff @(posedge clk) begin
    if (!nrst) begin
      opcode <= 8'h00;
      addr <= 24'h000000;
      fr_seen <= 1'b0;
    end else begin
      if (byte_ev && (lk_rx.idx == IDX_OPCODE)) begin
        opcode <= lk_rx.data;
      end
      if (byte_ev && (lk_rx.idx >= IDX_ADDR_FIRST) && (lk_rx.idx <= IDX_ADDR_LAST)) begin
        addr <= next_addr;
      end
      if (frame_end) begin
        fr_seen <= fr_sy[1];
      end
    end
  end

  // Read pointer; prefetched so the next byte waits before its load edge
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rd_ptr <= 4'h0;
    end else if (byte_ev && (lk_rx.idx == IDX_ADDR_LAST)) begin
      rd_ptr <= next_addr[GUARD_AW-1:0];
    end else if (byte_ev && (lk_rx.idx >= IDX_DATA)) begin
      rd_ptr <= rd_ptr + 4'h1;
    end
  end

  // Five-instruction sequence tracker; any wrong frame starts over
  always_ff @(posedge clk) begin
    if (!nrst) begin
      step <= 3'd0;
    end else if (frame_end && clocked) begin
      if (idle && ex1 && key_ok) begin
        step <= step + 3'd1;
      end else begin
        step <= 3'd0;
      end
    end
  end

  // Write enable latch
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wel <= 1'b0;
    end else if (take_wren) begin
      wel <= 1'b1;
    end else if (take_unlock || take_erase || take_prog) begin
      wel <= 1'b0;
    end
  end

  // Single unlocked sector, low twelve location bits dropped
  always_ff @(posedge clk) begin
    if (!nrst) begin
      unl <= '0;
    end else if (take_unlock) begin
      unl.valid <= 1'b1;
      unl.sector <= addr[SECTOR_MSB:SECTOR_LSB];
    end else if (take_lock) begin
      unl.valid <= 1'b0;
    end
  end

  // Program and erase sequencing with busy time
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st <= ST_IDLE;
      busy_cnt <= '0;
      erase_idx <= 4'h0;
      wr_ptr <= 4'h0;
      prog_cnt <= 9'h000;
    end else begin
      case (st)
        ST_IDLE: begin
          prog_cnt <= 9'h000;
          erase_idx <= 4'h0;
          if (take_prog) begin
            st <= ST_PROG;
          end else if (take_erase) begin
            st <= ST_ERASE;
          end
        end
        ST_PROG: begin
          if (byte_ev && (lk_rx.idx == IDX_ADDR_LAST)) begin
            wr_ptr <= next_addr[GUARD_AW-1:0];
          end else if (prog_we) begin
            wr_ptr <= wr_ptr + 4'h1;
            prog_cnt <= prog_cnt + 9'h001;
          end
          if (frame_end) begin
            // A frame with no whole data byte wrote nothing and costs no time
            st <= (prog_cnt != 9'h000) ? ST_BUSY : ST_IDLE;
            busy_cnt <= BUSY_W'(PROG_CYCLES - 1);
          end
        end
        ST_ERASE: begin
          erase_idx <= erase_idx + 4'h1;
          if (erase_idx == LOC_LAST) begin
            st <= ST_BUSY;
            busy_cnt <= BUSY_W'(ERASE_CYCLES - 1);
          end
        end
        ST_BUSY: begin
          if (busy_cnt == '0) begin
            st <= ST_IDLE;
          end else begin
            busy_cnt <= busy_cnt - 1'b1;
          end
        end
        default: begin
          st <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Guard storage
  // ****************************************
  logic mem_we;
  logic [3:0] mem_waddr;
  logic [7:0] mem_wdata;
  logic [7:0] rdata_b;
  logic [7:0] inhibit;

  assign mem_we = (st == ST_ERASE) || prog_we;
  assign mem_waddr = (st == ST_ERASE) ? erase_idx : wr_ptr;
  assign mem_wdata = (st == ST_ERASE) ? GUARD_ERASED : lk_rx.data;

  sgu_guard_mem u_mem (
    .clk(clk),
    .nrst(nrst),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr_a(rd_ptr),
    .rdata_a(rdata_a),
    .raddr_b({1'b0, query_addr[SECTOR_MSB:GROUP_LSB]}),
    .rdata_b(rdata_b),
    .inhibit(inhibit)
  );

  // ****************************************
  // Write permission query
  // ****************************************
  logic [5:0] q_sec;
  logic guard_bit;
  logic blk_lock;
  logic release_hit;

  assign guard_bit = rdata_b[q_sec[2:0]];
  assign blk_lock = block_locked({block_protect_bit2, block_protect_bit1, block_protect_bit0}, q_sec[5:4]);
  assign release_hit = unl.valid && (unl.sector == q_sec);

  // Two-stage lookup; guard zero wins over everything
  always_ff @(posedge clk) begin
    if (!nrst) begin
      q_sec <= 6'h00;
      query_writable <= 1'b0;
      whole_erase_blocked <= 1'b0;
    end else begin
      q_sec <= query_addr[SECTOR_MSB:SECTOR_LSB];
      query_writable <= guard_bit && (!blk_lock || release_hit);
      whole_erase_blocked <= (inhibit == INHIBIT_ON);
    end
  end

  assign guard_busy = (st != ST_IDLE);
  assign unlock_active = unl.valid;
  assign write_enable_latch = wel;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  a_guard_wins: assert property (!guard_bit |=> !query_writable)
    else $error("guard zero did not block write");
  a_open_sector: assert property (guard_bit && !blk_lock |=> query_writable)
    else $error("unguarded unprotected sector not writable");
  a_release_scope: assert property (guard_bit && blk_lock && !release_hit |=> !query_writable)
    else $error("protected sector writable without unlock");
  a_pack_locate: assert property ($past(nrst, 2) && $past(nrst) && !$past(blk_lock) |->
    query_writable == $past(u_mem.mem[query_addr[SECTOR_MSB:GROUP_LSB]][query_addr[SECTOR_LSB+2:SECTOR_LSB]], 2))
    else $error("sector bit selection wrong");
  a_read_advance: assert property (byte_ev && lk_rx.idx >= IDX_DATA |=> rd_ptr == $past(rd_ptr) + 4'h1)
    else $error("read location did not advance");
  a_unlock_exact: assert property ($rose(unl.valid) |-> $past(lk_bytes) == UNLOCK_BYTES
    && $past(lk_bits) == 3'd0 && $past(wel))
    else $error("unlock taken without exact frame");
  a_lock_clears: assert property (take_lock |=> !unl.valid)
    else $error("lock did not clear unlocked sector");
  a_one_sector: assert property ($past(unl.valid) && unl.valid |-> unl.sector == $past(unl.sector))
    else $error("unlocked sector changed without lock");
  a_seq_restart: assert property (frame_end && clocked && !(idle && ex1 && key_ok) |=> step == 3'd0)
    else $error("sequence not restarted");
  a_busy_hold: assert property (st == ST_BUSY && busy_cnt != '0 |=> st == ST_BUSY && guard_busy)
    else $error("busy ended early");
  a_read_stop: assert property (cs_sy[1] && cs_sy[2] |-> !serial_out_oe)
    else $error("output driven while deselected");

  c_unlock: cover property (take_unlock);
  c_erase: cover property (take_erase);
  c_prog_write: cover property (prog_we);
  c_read_data: cover property (serial_out_oe ##1 byte_ev);

endmodule // sgu_top

// File: verification/sgu_spi_host.sv
`timescale 1ns/10ps
// ****************************************
// Serial host model, mode 0
// ****************************************
module sgu_spi_host (
  output logic spi_sck,
  output logic spi_cs_n,
  output logic serial_in_line,
  input wire logic serial_out,
  input wire logic serial_out_oe
);
  logic [7:0] rd_byte;
  event got;

  // Idle bus: clock parked low, nothing selected
  initial begin
    spi_sck = 1'b0;
    spi_cs_n = 1'b1;
    serial_in_line = 1'b1;
    rd_byte = 8'h00;
  end

  // Send nbits MSB first, then clock in nrd bytes; clock stands still between frames
  task automatic frame(input logic [7:0] tx[$], input int nbits, input int nrd);
    int i;
    #33;
    spi_cs_n = 1'b0;
    for (i = 0; i < nbits + 8 * nrd; i++) begin
      #40;
      serial_in_line = (i < nbits) ? tx[i / 8][7 - i % 8] : ~serial_in_line;
      #40;
      spi_sck = 1'b1;
      if (i >= nbits) begin
        // Undriven line reads as the wrong level
        rd_byte = {rd_byte[6:0], serial_out_oe ? serial_out : ~serial_out};
        if ((i - nbits) % 8 == 7) begin
          -> got;
        end
      end
      #80;
      spi_sck = 1'b0;
    end
    #40;
    spi_cs_n = 1'b1;
    // Released line shows no stale level
    serial_in_line = ~serial_in_line;
    #100;
  endtask
endmodule // sgu_spi_host

// File: verification/tb_sgu_top.sv
`timescale 1ns/10ps
module tb_sgu_top;
  import sgu_pkg::*;
  // Short busy counts keep the run brief
  localparam int EC = 50;
  localparam int PC = 30;
  logic clk, nrst, spi_sck, spi_cs_n, serial_in_line, serial_out, serial_out_oe;
  logic [2:0] bp;
  logic [23:0] query_addr;
  logic query_writable, whole_erase_blocked, guard_busy, unlock_active, write_enable_latch;
  int fail_count = 0;
  int compares = 0;
  logic [7:0] exp_q[$];
  logic [7:0] guard[16];
  logic [7:0] tx[$];
  int s;

  sgu_top #(.ERASE_CYCLES(EC), .PROG_CYCLES(PC)) u_dut (
    .clk(clk), .nrst(nrst), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .serial_in_line(serial_in_line),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe), .block_protect_bit0(bp[0]),
    .block_protect_bit1(bp[1]), .block_protect_bit2(bp[2]), .query_addr(query_addr),
    .query_writable(query_writable), .whole_erase_blocked(whole_erase_blocked), .guard_busy(guard_busy),
    .unlock_active(unlock_active), .write_enable_latch(write_enable_latch));

  sgu_spi_host u_host (
    .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .serial_in_line(serial_in_line),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe));

  // ****************************************
  // Clock, compares, closing report
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check_flag(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic results();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Hang guard, well above the longest sequence
  initial begin
    repeat (100000) @(posedge clk);
    fail_count++;
    results();
  end

  // Read monitor: every byte clocked in is matched with the oldest note
  always @(u_host.got) begin
    check_flag("serial_out_oe", 1'b1, serial_out_oe);
    check_byte("guard_read", exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx, u_host.rd_byte);
  end

  // ****************************************
  // Command helpers
  // ****************************************
  task automatic cmd(input logic [7:0] b[$]);
    u_host.frame(b, 8 * b.size(), 0);
  endtask

  // Four key frames; one key corrupted when bad is 0 to 3
  task automatic keys(input int bad);
    int k;
    for (k = 0; k < 4; k++) begin
      cmd('{DEF_GUARD_KEYS[k] ^ {7'h00, k == bad}});
    end
  endtask

  task automatic wait_idle();
    int n;
    check_flag("guard_busy", 1'b1, guard_busy);
    for (n = 0; n < 400 && guard_busy !== 1'b0; n++) @(negedge clk);
    if (n >= 400) begin
      fail_count++;
      results();
    end
  endtask

  // Query result lands two clocks after the address
  task automatic query(input int sec, input logic exp);
    @(posedge clk);
    query_addr <= {6'h00, 6'(sec), 12'($urandom)};
    repeat (3) @(posedge clk);
    @(negedge clk);
    check_flag("query_writable", exp, query_writable);
  endtask

  // Unlock frame for a sector, low twelve bits random
  task automatic unlock(input int sec, input int nbits);
    logic [23:0] a;
    a = {6'h00, 6'(sec), 12'($urandom)};
    u_host.frame('{OP_UNLOCK, a[23:16], a[15:8], a[7:0]}, nbits, 0);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    nrst = 1'b0;
    bp = 3'h0;
    query_addr = 24'h000000;
    void'($urandom(32'h5b22b570));
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(negedge clk);
    check_flag("unlock_active", 1'b0, unlock_active);
    check_flag("whole_erase_blocked", 1'b0, whole_erase_blocked);
    check_flag("write_enable_latch", 1'b0, write_enable_latch);
    $display("test reset done");

    // Program refused after a corrupted key
    keys(2);
    cmd('{DEF_OP_GUARD_PROG, 8'h00, 8'h00, 8'h00, 8'h00});
    check_flag("guard_busy", 1'b0, guard_busy);
    // Program ten locations; sector 0 protected, 1 and 2 open
    for (s = 0; s < 16; s++) guard[s] = (s < 8) ? 8'($urandom) : 8'hff;
    guard[0] = 8'hfe;
    guard[8] = 8'h00;
    guard[9] = 8'h00;
    tx = '{DEF_OP_GUARD_PROG, 8'h00, 8'h00, 8'h00};
    for (s = 0; s < 10; s++) tx.push_back(guard[s]);
    keys(4);
    cmd(tx);
    wait_idle();
    check_flag("whole_erase_blocked", 1'b1, whole_erase_blocked);
    $display("test program done");

    // Read from location 5 across the wrap at 16
    for (s = 5; s < 18; s++) exp_q.push_back(guard[s % 16]);
    u_host.frame('{DEF_OP_GUARD_READ, 8'h00, 8'h00, 8'h05}, 32, 13);
    check_flag("serial_out_oe", 1'b0, serial_out_oe);
    check_flag("read_drained", 1'b1, exp_q.size() == 0);
    $display("test read done");

    // Every sector against its guard bit with no block protection
    for (s = 0; s < 64; s++) query(s, guard[s / 8][s % 8]);
    $display("test query done");

    // Unlock inside a fully protected array
    @(posedge clk);
    bp <= 3'h4;
    query(1, 1'b0);
    unlock(1, 32);
    check_flag("unlock_active", 1'b0, unlock_active);
    cmd('{OP_WREN});
    check_flag("write_enable_latch", 1'b1, write_enable_latch);
    unlock(1, 31);
    check_flag("unlock_active", 1'b0, unlock_active);
    cmd('{OP_WREN});
    unlock(1, 32);
    check_flag("unlock_active", 1'b1, unlock_active);
    check_flag("write_enable_latch", 1'b0, write_enable_latch);
    query(1, 1'b1);
    query(2, 1'b0);
    query(0, 1'b0);
    cmd('{OP_WREN});
    unlock(2, 32);
    query(2, 1'b0);
    cmd('{OP_LOCK});
    check_flag("unlock_active", 1'b0, unlock_active);
    query(1, 1'b0);
    @(posedge clk);
    bp <= 3'h0;
    $display("test unlock done");

    // Erase refused after a corrupted key, then accepted
    keys(1);
    cmd('{DEF_OP_GUARD_ERASE});
    check_flag("guard_busy", 1'b0, guard_busy);
    keys(4);
    cmd('{DEF_OP_GUARD_ERASE});
    wait_idle();
    check_flag("whole_erase_blocked", 1'b0, whole_erase_blocked);
    check_flag("write_enable_latch", 1'b0, write_enable_latch);
    query(0, 1'b1);
    $display("test erase done");
    results();
  end
endmodule // tb_sgu_top
